// ==== tes_defs.svh ====
/*
  Offsets, field positions, reset values and fixed codes for the transmit
  encoder and serializer. Assumes inclusion by bare name from its users.
*/
`ifndef TES_DEFS_SVH
`define TES_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TES_OFF_CTRL 8'h00
`define TES_OFF_TXREG 8'h04
`define TES_OFF_STATUS 8'h08

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TES_CTRL_SELFTEST_N 0
`define TES_CTRL_BYPASS_N 1
`define TES_CTRL_WIDTH_SEL 2
`define TES_CTRL_BAND_SEL 3
`define TES_CTRL_RANGE_SEL 4
`define TES_CTRL_ROUTE_LO 5
`define TES_CTRL_ROUTE_HI 6
`define TES_CTRL_IN_SEL 7
`define TES_CTRL_SRC_LO 8
`define TES_CTRL_SRC_HI 9
`define TES_CTRL_RESET 10'h007

// ----------------------------------------
// transmit input register fields
// ----------------------------------------
`define TES_TXREG_SPECIAL 12
`define TES_TXREG_VIOLATION 13
`define TES_TXREG_RESET 14'h0000

// ----------------------------------------
// status register fields
// ----------------------------------------
`define TES_ST_DISPARITY 0
`define TES_ST_MULT_LO 1
`define TES_ST_MULT_HI 5
`define TES_ST_LFSR_LO 6
`define TES_ST_LFSR_HI 14
`define TES_ST_WIDE 15

// ----------------------------------------
// character timing and fixed codes (bit 0 leaves first)
// ----------------------------------------
`define TES_LAST_BIT_10 4'h9
`define TES_LAST_BIT_12 4'hB
`define TES_FILL_INDEX 8'h05
`define TES_K285_NEG 10'h17C
`define TES_K285_POS 10'h283
`define TES_VIOL_CODE 10'h03F
`define TES_LFSR_SEED 9'h001
`define TES_SPECIAL_COUNT 4'hC

`endif

// ==== tes_pkg.sv ====
/*
  Types shared by the transmit encoder and serializer.
  Assumes nothing of its surroundings.
*/
package tes_pkg;
  // source that feeds the encoder holding register
  typedef enum logic [1:0] {
    TES_SRC_QUEUE = 2'h0,
    TES_SRC_INREG = 2'h1,
    TES_SRC_PACKER = 2'h2,
    TES_SRC_CONTROL = 2'h3
  } tes_src_e;

  // secondary serial output routing codes
  typedef enum logic [1:0] {
    TES_ROUTE_SER0 = 2'h0,
    TES_ROUTE_SER1 = 2'h1,
    TES_ROUTE_LEVEL = 2'h2,
    TES_ROUTE_RECLK = 2'h3
  } tes_route_e;
endpackage

// ==== tes_encoder.sv ====
/*
  8B/10B character encoder with its own running disparity.
  Assumes the caller pulses advance once per character actually encoded.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tes_defs.svh"

module tes_encoder
  import tes_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // character in
  input wire logic [7:0] char_in,
  input wire logic special,
  input wire logic violation,
  input wire logic advance,
  // code out, bit 0 first on the line
  output logic [9:0] code_out,
  output logic disparity
);
  logic [5:0] six; // abcdei, a in msb
  logic [3:0] four; // fghj, f in msb
  logic [4:0] xb; // 5b part
  logic [2:0] yb; // 3b part
  logic rd_mid; // disparity after the 6b sub-block
  logic next_disparity; // disparity after the whole code
  logic alt7; // alternate 3b/4b form
  logic bad; // violation or special index out of table

  // ----------------------------------------
  // 5b/6b table, negative disparity column
  // ----------------------------------------
  function automatic logic [5:0] tbl6(input logic [4:0] x);
    case (x)
      5'h00: tbl6 = 6'h27; 5'h01: tbl6 = 6'h1D; 5'h02: tbl6 = 6'h2D; 5'h03: tbl6 = 6'h31;
      5'h04: tbl6 = 6'h35; 5'h05: tbl6 = 6'h29; 5'h06: tbl6 = 6'h19; 5'h07: tbl6 = 6'h38;
      5'h08: tbl6 = 6'h39; 5'h09: tbl6 = 6'h25; 5'h0A: tbl6 = 6'h15; 5'h0B: tbl6 = 6'h34;
      5'h0C: tbl6 = 6'h0D; 5'h0D: tbl6 = 6'h2C; 5'h0E: tbl6 = 6'h1C; 5'h0F: tbl6 = 6'h17;
      5'h10: tbl6 = 6'h1B; 5'h11: tbl6 = 6'h23; 5'h12: tbl6 = 6'h13; 5'h13: tbl6 = 6'h32;
      5'h14: tbl6 = 6'h0B; 5'h15: tbl6 = 6'h2A; 5'h16: tbl6 = 6'h1A; 5'h17: tbl6 = 6'h3A;
      5'h18: tbl6 = 6'h33; 5'h19: tbl6 = 6'h26; 5'h1A: tbl6 = 6'h16; 5'h1B: tbl6 = 6'h36;
      5'h1C: tbl6 = 6'h0E; 5'h1D: tbl6 = 6'h2E; 5'h1E: tbl6 = 6'h1E; default: tbl6 = 6'h2B;
    endcase
  endfunction

  // 3b/4b table, negative disparity column
  function automatic logic [3:0] tbl4(input logic [2:0] y);
    case (y)
      3'h0: tbl4 = 4'hB; 3'h1: tbl4 = 4'h9; 3'h2: tbl4 = 4'h5; 3'h3: tbl4 = 4'hC;
      3'h4: tbl4 = 4'hD; 3'h5: tbl4 = 4'hA; 3'h6: tbl4 = 4'h6; default: tbl4 = 4'hE;
    endcase
  endfunction

  // ----------------------------------------
  // code selection
  // ----------------------------------------
  // special index 0..7 is K28.y, 8..11 the four K.x.7, the rest is a violation
  always_comb begin
    xb = char_in[4:0];
    yb = char_in[7:5];
    bad = violation;
    if (special) begin
      yb = 3'h7;
      case (char_in[3:0])
        4'h8: xb = 5'h17;
        4'h9: xb = 5'h1B;
        4'hA: xb = 5'h1D;
        4'hB: xb = 5'h1E;
        default: begin
          xb = 5'h1C;
          yb = char_in[2:0];
        end
      endcase
      if (char_in[3:0] >= `TES_SPECIAL_COUNT || char_in[7:4] != 4'h0) begin
        bad = 1'b1;
      end
    end
    // k28 has its own unbalanced 6b form, distinct from d28, so it always flips disparity
    six = (special && xb == 5'h1C) ? 6'h0F : tbl6(xb);
    rd_mid = disparity ^ ($countones(six) != 3);
    if (disparity && ($countones(six) != 3 || xb == 5'h07)) begin
      six = ~six;
    end
    alt7 = (yb == 3'h7) && (special || (!rd_mid && (xb == 5'h11 || xb == 5'h12 || xb == 5'h14))
           || (rd_mid && (xb == 5'h0B || xb == 5'h0D || xb == 5'h0E)));
    four = alt7 ? 4'h7 : tbl4(yb);
    next_disparity = rd_mid ^ ($countones(four) != 2);
    if (rd_mid && ($countones(four) != 2 || yb == 3'h3)) begin
      four = ~four;
    end else if (!rd_mid && special && xb == 5'h1C && yb != 3'h3 && $countones(four) == 2) begin
      // balanced k28 tails take the opposite form of the data tails
      four = ~four;
    end
    for (int i = 0; i < 6; i++) begin
      code_out[i] = six[5 - i];
    end
    for (int i = 0; i < 4; i++) begin
      code_out[6 + i] = four[3 - i];
    end
    if (bad) begin
      code_out = `TES_VIOL_CODE;
      next_disparity = disparity;
    end
  end

  // ----------------------------------------
  // running disparity, moves only on encoded characters
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disparity <= 1'b0;
    end else if (advance) begin
      disparity <= next_disparity;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CODE_BALANCED: assert property (@(posedge aclk) disable iff (!aresetn)
    (!violation && !special) |-> ($countones(code_out) inside {4, 5, 6}))
    else $error("data code has illegal weight");
  AST_VIOLATION_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    violation |-> (code_out == `TES_VIOL_CODE))
    else $error("violation force did not give the violation code");
endmodule // tes_encoder

`default_nettype wire

// ==== tes_tx_encoder_serializer.sv ====
/*
  Transmit back end: holding register with four sources and a self-test
  generator, 8B/10B encoder or bypass, LSB-first serializer, secondary output
  routing, AXI4-Lite control. Assumes inputs synchronous to aclk; the bit
  clock is aclk and the character clock is derived from it.
*/
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tes_defs.svh"

// Functional notes
// - holding register loads from four sources
// - self-test makes holding register a 511-step LFSR
// - special select high uses special table
// - special select low encodes data character
// - violation force sends violation symbol instead
// - encoder maps 8-bit data to 10-bit codes
// - bypass passes 10/12-bit character unchanged
// - serializer takes one character per character time
// - multiplier 2.5, 5 or 10 by selects
// - 12-bit raw mode multiplier 3, 6, 12
// - bits leave least significant first
// - load timing from internal counter only
// - route 10 level copy, 11 reclocked copy
// - primary carries serializer, secondary the route
// - reclocked route retimes with recovered clock
// - character-rate clock also produced
// - band and range select line and reference rates
// - encoder keeps disparity; bypass fill untracked
module tes_tx_encoder_serializer
  import tes_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // character sources
  input wire logic [11:0] queue_char,
  input wire logic queue_special,
  input wire logic queue_violation,
  input wire logic queue_valid,
  input wire logic [7:0] packer_char,
  input wire logic packer_valid,
  input wire logic [3:0] ctrl_char,
  output logic source_take,
  // serial lines
  input wire logic serial_in_first,
  input wire logic serial_in_second,
  input wire logic recovered_bit_strobe,
  output logic serial_out_primary,
  output logic serial_out_secondary,
  output logic char_tick
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [9:0] ctrl; // control register
  logic [13:0] txreg; // transmit input register
  logic [11:0] hold_char; // encoder holding register
  logic hold_sc; // held special select
  logic hold_svs; // held violation force
  logic hold_fill; // held raw fill in bypass
  logic fill_pos; // next raw fill polarity
  logic [3:0] bit_cnt; // bit position in the character
  logic [11:0] shreg; // transmit shifter
  logic reclk_bit; // input bit caught on recovered clock
  logic [9:0] enc_code; // encoder result
  logic enc_disp; // running disparity
  logic [11:0] word; // parallel character for the shifter
  logic [4:0] mult_x2; // bit clock multiplier, doubled
  logic selftest_n; // self-test enable, low active
  logic coder_bypass_n; // encoder bypass, low active
  logic wide; // 12-bit raw characters
  logic load; // last bit of the character
  logic lfsr_fb; // self-test feedback
  logic sel_in; // selected serial input
  logic [31:0] wmask; // byte-lane write mask
  logic [31:0] rd_word; // read mux
  logic rd_ok; // read address mapped
  logic wr_ok; // write address mapped
  tes_src_e src; // selected source
  tes_route_e route; // secondary routing

  assign selftest_n = ctrl[`TES_CTRL_SELFTEST_N];
  assign coder_bypass_n = ctrl[`TES_CTRL_BYPASS_N];
  assign wide = !ctrl[`TES_CTRL_WIDTH_SEL] && !coder_bypass_n;
  assign src = tes_src_e'(ctrl[`TES_CTRL_SRC_HI:`TES_CTRL_SRC_LO]);
  assign route = tes_route_e'(ctrl[`TES_CTRL_ROUTE_HI:`TES_CTRL_ROUTE_LO]);
  assign sel_in = ctrl[`TES_CTRL_IN_SEL] ? serial_in_second : serial_in_first;
  assign load = bit_cnt >= (wide ? `TES_LAST_BIT_12 : `TES_LAST_BIT_10);
  assign lfsr_fb = hold_char[8] ^ hold_char[4];

  // ----------------------------------------
  // multiplier factor from band, range and width
  // ----------------------------------------
  // band high doubles the line rate; range high halves the factor for a faster reference
  always_comb begin
    case ({ctrl[`TES_CTRL_BAND_SEL], ctrl[`TES_CTRL_RANGE_SEL]})
      2'b00: mult_x2 = wide ? 5'h0C : 5'h0A;
      2'b01: mult_x2 = wide ? 5'h06 : 5'h05;
      2'b10: mult_x2 = wide ? 5'h18 : 5'h14;
      default: mult_x2 = wide ? 5'h0C : 5'h0A;
    endcase
  end

  // ----------------------------------------
  // encoder
  // ----------------------------------------
  tes_encoder u_enc (
    .aclk(aclk),
    .aresetn(aresetn),
    .char_in(hold_char[7:0]),
    .special(hold_sc),
    .violation(hold_svs),
    .advance(load && (coder_bypass_n || !selftest_n)),
    .code_out(enc_code),
    .disparity(enc_disp)
  );

  // parallel word: encoded, raw fill, or raw pass-through
  always_comb begin
    if (coder_bypass_n || !selftest_n) begin
      word = {2'b00, enc_code};
    end else if (hold_fill) begin
      word = {2'b00, fill_pos ? `TES_K285_POS : `TES_K285_NEG};
    end else begin
      word = wide ? hold_char : {2'b00, hold_char[9:0]};
    end
  end

  // ----------------------------------------
  // character counter, free running
  // ----------------------------------------
  // pins never steer the load moment, so a late source only misses a slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= 4'h0;
      char_tick <= 1'b0;
    end else begin
      bit_cnt <= load ? 4'h0 : bit_cnt + 4'h1;
      char_tick <= load;
    end
  end

  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg <= 12'h000;
      serial_out_primary <= 1'b0;
    end else begin
      shreg <= load ? word : {1'b0, shreg[11:1]};
      serial_out_primary <= shreg[0];
    end
  end

  // ----------------------------------------
  // holding register and its sources
  // ----------------------------------------
  // empty sources give a fill: K28.5 when encoding, a raw alternating pair when bypassed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_char <= 12'h000;
      hold_sc <= 1'b0;
      hold_svs <= 1'b0;
      hold_fill <= 1'b0;
      fill_pos <= 1'b0;
      source_take <= 1'b0;
    end else begin
      source_take <= 1'b0;
      if (load) begin
        hold_fill <= 1'b0;
        hold_svs <= 1'b0;
        if (hold_fill) begin
          fill_pos <= !fill_pos;
        end
        if (!selftest_n) begin
          hold_char <= (hold_char[8:0] == 9'h000) ? {3'h0, `TES_LFSR_SEED} :
                       {3'h0, hold_char[7:0], lfsr_fb};
          hold_sc <= hold_char[7];
        end else begin
          case (src)
            TES_SRC_QUEUE: begin
              hold_char <= queue_char;
              hold_sc <= queue_special;
              hold_svs <= queue_violation;
              source_take <= queue_valid;
            end
            TES_SRC_INREG: begin
              hold_char <= txreg[11:0];
              hold_sc <= txreg[`TES_TXREG_SPECIAL];
              hold_svs <= txreg[`TES_TXREG_VIOLATION];
            end
            TES_SRC_PACKER: begin
              hold_char <= {4'h0, packer_char};
              hold_sc <= 1'b0;
              source_take <= packer_valid;
            end
            default: begin
              hold_char <= {8'h00, ctrl_char};
              hold_sc <= 1'b1;
            end
          endcase
          if ((src == TES_SRC_QUEUE && !queue_valid) || (src == TES_SRC_PACKER && !packer_valid)) begin
            hold_char <= {4'h0, `TES_FILL_INDEX};
            hold_sc <= 1'b1;
            hold_svs <= 1'b0;
            hold_fill <= !coder_bypass_n;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // secondary output routing
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reclk_bit <= 1'b0;
    end else if (recovered_bit_strobe) begin
      reclk_bit <= sel_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_secondary <= 1'b0;
    end else begin
      case (route)
        TES_ROUTE_LEVEL: serial_out_secondary <= sel_in;
        TES_ROUTE_RECLK: serial_out_secondary <= reclk_bit;
        default: serial_out_secondary <= shreg[0];
      endcase
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // address and data are taken together in one beat; the slave simply waits for both
  assign wr_ok = s_axi_awaddr == `TES_OFF_CTRL || s_axi_awaddr == `TES_OFF_TXREG
                 || s_axi_awaddr == `TES_OFF_STATUS;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `TES_CTRL_RESET;
      txreg <= `TES_TXREG_RESET;
    end else if (s_axi_awvalid && s_axi_awready) begin
      if (s_axi_awaddr == `TES_OFF_CTRL) begin
        ctrl <= (ctrl & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
      end
      if (s_axi_awaddr == `TES_OFF_TXREG) begin
        txreg <= (txreg & ~wmask[13:0]) | (s_axi_wdata[13:0] & wmask[13:0]);
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TES_OFF_CTRL: rd_word[9:0] = ctrl;
      `TES_OFF_TXREG: rd_word[13:0] = txreg;
      `TES_OFF_STATUS: begin
        rd_word[`TES_ST_DISPARITY] = enc_disp;
        rd_word[`TES_ST_MULT_HI:`TES_ST_MULT_LO] = mult_x2;
        rd_word[`TES_ST_LFSR_HI:`TES_ST_LFSR_LO] = hold_char[8:0];
        rd_word[`TES_ST_WIDE] = wide;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_load_raw;
    load && !coder_bypass_n && selftest_n && !hold_fill;
  endsequence

  AST_HOLD_ON_TICK: assert property ($changed(hold_char) |-> $past(load))
    else $error("holding register moved off the character clock");
  AST_LSB_FIRST: assert property (load |=> (shreg == $past(word)) ##1 (serial_out_primary == $past(word[0], 2)))
    else $error("character did not leave lsb first");
  AST_BYPASS_RAW: assert property (seq_load_raw ##0 !wide |=> shreg[9:0] == $past(hold_char[9:0]))
    else $error("bypassed character was modified");
  AST_TEN_BIT_SLOT: assert property ((load && !wide) ##1 !wide[*8] |-> !load ##1 !load ##1 (load || wide))
    else $error("ten-bit character slot has wrong length");
  AST_WIDE_MULT: assert property (wide |-> mult_x2 inside {5'h06, 5'h0C, 5'h18})
    else $error("raw twelve-bit mode multiplier wrong");
  AST_LFSR_STEP: assert property ((load && !selftest_n && hold_char[8:0] != 9'h000)
    |=> hold_char[8:0] == {$past(hold_char[7:0]), $past(hold_char[8]) ^ $past(hold_char[4])})
    else $error("self-test register did not step");
  AST_RECLOCK_ROUTE: assert property ((route == TES_ROUTE_RECLK && $stable(route)) |-> serial_out_secondary == $past(reclk_bit))
    else $error("reclocked route not retimed");
  AST_PRIMARY_SERIAL: assert property (serial_out_primary == $past(shreg[0]))
    else $error("primary output not from the shifter");
endmodule // tes_tx_encoder_serializer

`default_nettype wire

// ==== tes_far_rx.sv ====
/* far-side receiver model: drives both serial inputs and the recovered
   strobe, regathers characters from the primary line. assumes aclk is the bit clock */
`timescale 1ns/1ps
`default_nettype none
module tes_far_rx (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lines from the block
  input wire logic serial_out_primary,
  input wire logic char_tick,
  // lines into the block
  output logic serial_in_first,
  output logic serial_in_second,
  output logic recovered_bit_strobe,
  // regathered character
  output logic [11:0] rx_word,
  output logic rx_valid
);
  logic [5:0] cnt; // slow pattern, so a copied line can be judged mid-bit
  logic [11:0] sh; // bits of the character in flight
  logic [3:0] bitn; // next bit position
  logic tick_d; // char_tick one cycle late, when bit 0 is on the line
  assign serial_in_first = cnt[4];
  assign serial_in_second = ~cnt[5];
  assign recovered_bit_strobe = (cnt[1:0] == 2'h0);
  // bit 0 lands one cycle after char_tick; the previous character is whole by then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 6'h00;
      rx_valid <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      cnt <= cnt + 6'h01;
      tick_d <= char_tick;
      rx_valid <= tick_d;
      if (tick_d) begin
        rx_word <= sh;
        sh <= {11'h000, serial_out_primary};
        bitn <= 4'h1;
      end else begin
        sh[bitn] <= serial_out_primary;
        bitn <= bitn + 4'h1;
      end
    end
  end
endmodule // tes_far_rx
`default_nettype wire

// ==== tb.sv ====
/* self-checking bench for the transmit back end; notes queued by stimulus,
   taken by the line monitor. assumes tes_far_rx on the serial side */
`timescale 1ns/1ps
`default_nettype none
`include "tes_defs.svh"
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, packer_char;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, s0;
  logic [3:0] s_axi_wstrb, ctrl_char;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, source_take;
  logic [11:0] queue_char, rx_word;
  logic queue_special, queue_violation, queue_valid, packer_valid, serial_in_first, serial_in_second;
  logic recovered_bit_strobe, serial_out_primary, serial_out_secondary, char_tick, rx_valid, sel, v;
  logic [23:0] exp_q[$]; // expected word, alternative in the upper half
  logic [23:0] me;
  int fails = 0;
  int check_count = 0;
  int n;
  tes_tx_encoder_serializer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .queue_char, .queue_special, .queue_violation, .queue_valid, .packer_char,
    .packer_valid, .ctrl_char, .source_take, .serial_in_first, .serial_in_second, .recovered_bit_strobe,
    .serial_out_primary, .serial_out_secondary, .char_tick);
  tes_far_rx far (.aclk, .aresetn, .serial_out_primary, .char_tick, .serial_in_first,
    .serial_in_second, .recovered_bit_strobe, .rx_word, .rx_valid);
  always #10 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic tick(input int k);
    repeat (k) do @(posedge aclk); while (char_tick !== 1'b1);
  endtask
  // settle a mode, then note one line word and wait for the monitor
  task automatic sendw(input logic [31:0] c, input logic [31:0] t, input logic [23:0] e);
    axw(`TES_OFF_CTRL, c, 2'h0);
    axw(`TES_OFF_TXREG, t, 2'h0);
    tick(3);
    exp_q.push_back(e);
    while (exp_q.size() > 0) @(posedge aclk);
  endtask
  // status read at a fixed phase after a character tick
  task automatic st_read(input int k);
    tick(k);
    repeat (2) @(posedge aclk);
    axr(`TES_OFF_STATUS, rd, rs);
  endtask
  always @(posedge aclk) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      chk("line word", {20'h0, me[11:0]}, {20'h0, (rx_word === me[23:12]) ? me[11:0] : rx_word});
    end
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {queue_special, queue_violation, queue_valid, packer_valid, packer_char, ctrl_char} = 16'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, queue_char} = 60'h0;
    s_axi_wstrb = 4'hF;
    n = $urandom(36);
    repeat (6) @(posedge aclk);
    chk("reset out", 32'h0, {26'h0, serial_out_primary, serial_out_secondary, char_tick, source_take,
      s_axi_bvalid, s_axi_rvalid});
    aresetn <= 1'b1;
    axr(`TES_OFF_CTRL, rd, rs);
    chk("ctrl reset", 32'h007, rd);
    axr(8'h0C, rd, rs);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    axw(8'h0C, 32'h0, 2'h2);
    $display("test reset and map done");
    n = $urandom;
    sendw(32'h105, n & 32'h3FF, {2{n[11:0] & 12'h3FF}});
    sendw(32'h101, n & 32'hFFF, {2{n[11:0]}});
    sendw(32'h107, 32'h2000 | (n & 32'hFF), {2{2'h0, `TES_VIOL_CODE}});
    sendw(32'h107, 32'h00B5, {2{12'h155}});
    ctrl_char <= 4'h5;
    sendw(32'h307, 32'h0, {2'h0, `TES_K285_POS, 2'h0, `TES_K285_NEG});
    sendw(32'h007, 32'h0, {2'h0, `TES_K285_POS, 2'h0, `TES_K285_NEG});
    queue_char <= n[11:0] & 12'h3FF;
    queue_valid <= 1'b1;
    sendw(32'h005, 32'h0, {2{n[11:0] & 12'h3FF}});
    tick(1);
    chk("source take", 32'h1, {31'h0, source_take});
    $display("test characters done");
    for (int i = 0; i < 8; i++) begin
      axw(`TES_OFF_CTRL, {27'h0, i[0], i[1], i[2], 2'h1}, 2'h0);
      axr(`TES_OFF_STATUS, rd, rs);
      chk("mult x2", ((i[2] ? 32'hA : 32'hC) << i[1]) >> i[0], {27'h0, rd[5:1]});
      chk("wide", {31'h0, !i[2]}, {31'h0, rd[15]});
      tick(2);
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (char_tick !== 1'b1);
      chk("char period", i[2] ? 32'd10 : 32'd12, n);
      chk("route serializer", {31'h0, serial_out_primary}, {31'h0, serial_out_secondary});
    end
    $display("test rates done");
    for (int j = 0; j < 4; j++) begin
      axw(`TES_OFF_CTRL, {24'h0, j[1], 1'b1, j[0], 5'h07}, 2'h0);
      sel = j[1];
      v = sel ? serial_in_second : serial_in_first;
      do @(posedge aclk); while ((sel ? serial_in_second : serial_in_first) === v);
      repeat (8) @(posedge aclk);
      chk("secondary", {31'h0, sel ? serial_in_second : serial_in_first}, {31'h0, serial_out_secondary});
    end
    $display("test routes done");
    axw(`TES_OFF_CTRL, 32'h006, 2'h0);
    st_read(2);
    s0 = rd;
    st_read(1);
    chk("lfsr moves", 32'h1, {31'h0, rd[14:6] !== s0[14:6]});
    st_read(510);
    chk("lfsr period", {23'h0, s0[14:6]}, {23'h0, rd[14:6]});
    $display("test self-test done");
    close_out();
  end
  initial begin
    #800000;
    fails++;
    close_out();
  end
endmodule // tb
`default_nettype wire
